// >>> verilog/csm_slot_mapper.sv
// Slot mapper for output channels two to four of the audio serial port, with APB registers.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module csm_slot_mapper (
  input  wire logic                pclk,                // System clock, 200 MHz.
  input  wire logic                presetn,             // Asynchronous reset, active low.
  input  wire logic                psel,                // APB select.
  input  wire logic                penable,             // APB access phase.
  input  wire logic                pwrite,              // APB write.
  input  wire logic [11:0]         paddr,               // APB byte address.
  input  wire logic [31:0]         pwdata,              // APB write data.
  input  wire logic [3:0]          pstrb,               // APB byte strobes.
  output logic      [31:0]         prdata,              // APB read data.
  output logic                     pready,              // APB ready.
  output logic                     pslverr,             // APB error.
  input  wire logic                frame_valid,         // Sample frame offered.
  output logic                     frame_ready,         // FIFO can take a frame.
  input  wire csm_pkg::csm_frame_t frame_data,          // Samples of channels two to four.
  input  wire logic                bit_clock_pin,       // Serial bit clock from the host.
  input  wire logic                frame_sync_pin,      // Serial frame sync from the host.
  output logic                     primary_serial_out,  // Primary data line.
  output logic                     primary_serial_oe_n, // Primary line drive enable, low drives.
  output logic                     general_output_pin,  // Secondary data line.
  output logic                     general_output_oe_n  // Secondary line drive enable, low drives.
);

  import csm_pkg::*;

  typedef struct packed {
    csm_chan_cfg_t [2:0] chan;
    logic [1:0]          fmt;
    logic                underrun;
    logic                seen;
    logic [31:0]         rdata;
    logic [2:0]          bclk_sync;
    logic [2:0]          fsync_sync;
    logic                bclk_lvl;
    logic                fsync_lvl;
    logic                fs_prev;
    logic [11:0]         pos;
    logic                half;
    csm_frame_t          frame;
    logic                pri_out;
    logic                pri_oe_n;
    logic                sec_out;
    logic                sec_oe_n;
  } csm_state_t;

  csm_state_t       st_ff;
  csm_state_t       nxt_st;
  logic             fifo_valid;
  csm_frame_t       fifo_data;
  logic             fifo_pop;
  logic [5:0]       fifo_level;
  logic [9:0]       reg_idx;
  logic             reg_known;
  logic             apb_setup;
  logic             apb_access;
  logic             bclk_rise;
  logic             bclk_fall;
  logic             fs_now;
  logic             frame_start;
  logic [2:0]       hit;
  logic [2:0]       bit_val;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample FIFO.

  csm_fifo #(
    .WIDTH ($bits(csm_frame_t)),
    .DEPTH (CSM_FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (frame_valid),
    .in_ready  (frame_ready),
    .in_data   (frame_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the update logic and the checks.

  assign reg_idx    = paddr[11:2];
  assign reg_known  = (paddr[1:0] == 2'h0) &&
                      ((reg_idx == CSM_IDX_CHAN_TWO) || (reg_idx == CSM_IDX_CHAN_THREE) ||
                       (reg_idx == CSM_IDX_CHAN_FOUR) || (reg_idx == CSM_IDX_FRAME_CFG) ||
                       (reg_idx == CSM_IDX_STATUS));
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;

  // A pin change counts once the second and third stages agree.
  assign bclk_rise  = (st_ff.bclk_sync[1] == st_ff.bclk_sync[2]) && st_ff.bclk_sync[2] && !st_ff.bclk_lvl;
  assign bclk_fall  = (st_ff.bclk_sync[1] == st_ff.bclk_sync[2]) && !st_ff.bclk_sync[2] && st_ff.bclk_lvl;
  assign fs_now     = (st_ff.fsync_sync[1] == st_ff.fsync_sync[2]) ? st_ff.fsync_sync[2] : st_ff.fsync_lvl;

  // TDM and left-justified frames open on the sync rising edge; I2S frames on the falling edge.
  always_comb begin
    frame_start = 1'b0;
    if (bclk_rise && (fs_now != st_ff.fs_prev)) begin
      if (csm_is_tdm(st_ff.fmt)) begin
        frame_start = fs_now;
      end else if (st_ff.fmt == CSM_FMT_I2S) begin
        frame_start = !fs_now;
      end else begin
        frame_start = fs_now;
      end
    end
  end

  assign fifo_pop = frame_start && fifo_valid;

  assign hit[0] = st_ff.seen && csm_slot_hit(st_ff.chan[0].slot_idx, st_ff.pos, st_ff.fmt, st_ff.half);
  assign hit[1] = st_ff.seen && csm_slot_hit(st_ff.chan[1].slot_idx, st_ff.pos, st_ff.fmt, st_ff.half);
  assign hit[2] = st_ff.seen && csm_slot_hit(st_ff.chan[2].slot_idx, st_ff.pos, st_ff.fmt, st_ff.half);

  // Samples go out MSB first, so the bit index is the inverted position in the slot.
  assign bit_val[0] = st_ff.frame.chan_two[~st_ff.pos[4:0]];
  assign bit_val[1] = st_ff.frame.chan_three[~st_ff.pos[4:0]];
  assign bit_val[2] = st_ff.frame.chan_four[~st_ff.pos[4:0]];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic [2:0] on_pri;
    logic [2:0] on_sec;
    logic       clr_underrun;
    on_pri       = '0;
    on_sec       = '0;
    clr_underrun = 1'b0;
    nxt_st       = st_ff;

    nxt_st.bclk_sync  = {st_ff.bclk_sync[1:0], bit_clock_pin};
    nxt_st.fsync_sync = {st_ff.fsync_sync[1:0], frame_sync_pin};
    if (st_ff.bclk_sync[1] == st_ff.bclk_sync[2]) begin
      nxt_st.bclk_lvl = st_ff.bclk_sync[2];
    end
    nxt_st.fsync_lvl = fs_now;

    // Register reads are captured in the setup phase and shown in the access phase.
    if (apb_setup) begin
      nxt_st.rdata = '0;
      case (reg_idx)
        CSM_IDX_CHAN_TWO: begin
          nxt_st.rdata[6:0] = st_ff.chan[0];
        end
        CSM_IDX_CHAN_THREE: begin
          nxt_st.rdata[6:0] = st_ff.chan[1];
        end
        CSM_IDX_CHAN_FOUR: begin
          nxt_st.rdata[6:0] = st_ff.chan[2];
        end
        CSM_IDX_FRAME_CFG: begin
          nxt_st.rdata[1:0] = st_ff.fmt;
        end
        CSM_IDX_STATUS: begin
          nxt_st.rdata[CSM_STAT_UNDERRUN]                  = st_ff.underrun;
          nxt_st.rdata[CSM_STAT_LEVEL_LSB +: 6]            = fifo_level;
          nxt_st.rdata[CSM_STAT_ACTIVE]                    = st_ff.seen;
        end
        default: begin
          nxt_st.rdata = '0;
        end
      endcase
      if (paddr[1:0] != 2'h0) begin
        nxt_st.rdata = '0;
      end
    end

    // Writes land at the completing access edge; bit 7 of a channel register is dropped.
    if (apb_access && pwrite && reg_known && pstrb[0]) begin
      case (reg_idx)
        CSM_IDX_CHAN_TWO: begin
          nxt_st.chan[0] = pwdata[6:0];
        end
        CSM_IDX_CHAN_THREE: begin
          nxt_st.chan[1] = pwdata[6:0];
        end
        CSM_IDX_CHAN_FOUR: begin
          nxt_st.chan[2] = pwdata[6:0];
        end
        CSM_IDX_FRAME_CFG: begin
          nxt_st.fmt = pwdata[1:0];
        end
        CSM_IDX_STATUS: begin
          clr_underrun = pwdata[CSM_STAT_UNDERRUN];
        end
        default: begin
          clr_underrun = 1'b0;
        end
      endcase
    end
    if (clr_underrun) begin
      nxt_st.underrun = 1'b0;
    end

    // Bit position follows the host's bit clock; the sync is sampled on its rising edge.
    if (bclk_rise) begin
      nxt_st.fs_prev = fs_now;
      if (fs_now != st_ff.fs_prev) begin
        if (csm_is_tdm(st_ff.fmt)) begin
          if (fs_now) begin
            nxt_st.pos  = CSM_POS_FIRST;
            nxt_st.half = 1'b0;
            nxt_st.seen = 1'b1;
          end else if (st_ff.pos != CSM_POS_LAST) begin
            nxt_st.pos = 12'(st_ff.pos + 12'h001);
          end
        end else if (st_ff.fmt == CSM_FMT_I2S) begin
          // I2S puts the MSB one bit clock after the sync edge; low sync is the left half.
          nxt_st.pos  = CSM_POS_I2S_FIRST;
          nxt_st.half = fs_now;
          nxt_st.seen = 1'b1;
        end else begin
          nxt_st.pos  = CSM_POS_FIRST;
          nxt_st.half = !fs_now;
          nxt_st.seen = 1'b1;
        end
      end else if (st_ff.pos != CSM_POS_LAST) begin
        nxt_st.pos = 12'(st_ff.pos + 12'h001);
      end
      if (frame_start) begin
        if (fifo_valid) begin
          nxt_st.frame = fifo_data;
        end else begin
          // An empty FIFO sends silence rather than repeating old samples.
          nxt_st.frame    = '0;
          nxt_st.underrun = 1'b1;
        end
      end
    end

    // Data changes on the falling edge so the host samples it stable on the rising edge.
    if (bclk_fall) begin
      for (int i = 0; i < 3; i++) begin
        on_pri[i] = hit[i] && !st_ff.chan[i].line_sel;
        on_sec[i] = hit[i] && st_ff.chan[i].line_sel;
      end
      nxt_st.pri_oe_n = !(|on_pri);
      nxt_st.sec_oe_n = !(|on_sec);
      nxt_st.pri_out  = |(on_pri & bit_val);
      nxt_st.sec_out  = |(on_sec & bit_val);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.chan[0]  <= CSM_RST_CHAN_TWO;
      st_ff.chan[1]  <= CSM_RST_CHAN_THREE;
      st_ff.chan[2]  <= CSM_RST_CHAN_FOUR;
      st_ff.fmt      <= CSM_RST_FORMAT;
      st_ff.pri_oe_n <= 1'b1;
      st_ff.sec_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata              = st_ff.rdata;
  assign pready              = 1'b1;
  assign pslverr             = apb_access && !reg_known;
  assign primary_serial_out  = st_ff.pri_out;
  assign primary_serial_oe_n = st_ff.pri_oe_n;
  assign general_output_pin  = st_ff.sec_out;
  assign general_output_oe_n = st_ff.sec_oe_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_fall_two_primary;
    bclk_fall && hit[0] && !st_ff.chan[0].line_sel;
  endsequence

  sequence s_fall_three_secondary;
    bclk_fall && hit[1] && st_ff.chan[1].line_sel;
  endsequence

  sequence s_tdm_slot_three;
    bclk_fall && st_ff.seen && csm_is_tdm(st_ff.fmt) && !st_ff.pos[11] &&
    (st_ff.pos[10:5] == st_ff.chan[1].slot_idx);
  endsequence

  sequence s_left_slot_four;
    bclk_fall && st_ff.seen && !csm_is_tdm(st_ff.fmt) && !st_ff.half && !st_ff.pos[11] &&
    !st_ff.pos[10] && !st_ff.chan[2].slot_idx[5] && (st_ff.pos[9:5] == st_ff.chan[2].slot_idx[4:0]);
  endsequence

  sequence s_right_slot_two;
    bclk_fall && st_ff.seen && !csm_is_tdm(st_ff.fmt) && st_ff.half && !st_ff.pos[11] &&
    !st_ff.pos[10] && st_ff.chan[0].slot_idx[5] &&
    (st_ff.pos[9:5] == 5'(st_ff.chan[0].slot_idx - 6'h20));
  endsequence

  sequence s_read_chan_reg;
    apb_setup && !pwrite && (paddr[1:0] == 2'h0) &&
    ((reg_idx == CSM_IDX_CHAN_TWO) || (reg_idx == CSM_IDX_CHAN_THREE) || (reg_idx == CSM_IDX_CHAN_FOUR));
  endsequence

  property p_line_follows(s_cause, logic oe_n);
    s_cause |=> !oe_n;
  endproperty

  a_primary_line_drive: assert property (p_line_follows(s_fall_two_primary, primary_serial_oe_n))
    else $error("channel two on primary line did not drive primary pin");

  a_secondary_line_drive: assert property (p_line_follows(s_fall_three_secondary, general_output_oe_n))
    else $error("channel three on secondary line did not drive secondary pin");

  a_tdm_slot_match: assert property (s_tdm_slot_three |=>
      ($past(st_ff.chan[1].line_sel) ? !general_output_oe_n : !primary_serial_oe_n))
    else $error("TDM slot equal to channel three index not driven");

  a_left_half_slot: assert property (s_left_slot_four |-> hit[2] ##1
      ($past(st_ff.chan[2].line_sel) ? !general_output_oe_n : !primary_serial_oe_n))
    else $error("left half slot of channel four not driven");

  a_right_half_slot: assert property (s_right_slot_two |-> hit[0] ##1
      ($past(st_ff.chan[0].line_sel) ? !general_output_oe_n : !primary_serial_oe_n))
    else $error("right half slot of channel two not driven");

  a_wrong_half_idle: assert property ((bclk_fall && !csm_is_tdm(st_ff.fmt) &&
      (st_ff.chan[0].slot_idx[5] != st_ff.half)) |-> !hit[0])
    else $error("channel two hit in the wrong half frame");

  a_reset_chan_three: assert property ($rose(presetn) |-> (st_ff.chan[1] == CSM_RST_CHAN_THREE))
    else $error("channel three register reset value wrong");

  a_reset_chan_four: assert property ($rose(presetn) |-> (st_ff.chan[2] == CSM_RST_CHAN_FOUR))
    else $error("channel four register reset value wrong");

  a_reset_chan_two: assert property ($rose(presetn) |-> (st_ff.chan[0] == CSM_RST_CHAN_TWO))
    else $error("channel two register reset value wrong");

  a_reserved_reads_zero: assert property (s_read_chan_reg |=> (prdata[31:7] == 25'h0000000))
    else $error("reserved bits of channel register read nonzero");

  a_write_then_read: assert property ((apb_access && pwrite && pstrb[0] && (paddr == 12'h030)) ##1
      (apb_setup && !pwrite && (paddr == 12'h030)) |=> (prdata[6:0] == $past(pwdata[6:0], 2)))
    else $error("channel two register did not keep written value");

endmodule
`default_nettype wire

// >>> shared/csm_pkg.sv
// Register map, field layout, types and slot decoding of the channel slot mapper.
package csm_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [9:0]  CSM_IDX_CHAN_TWO   = 10'h00C;
  localparam logic [9:0]  CSM_IDX_CHAN_THREE = 10'h00D;
  localparam logic [9:0]  CSM_IDX_CHAN_FOUR  = 10'h00E;
  localparam logic [9:0]  CSM_IDX_FRAME_CFG  = 10'h010;
  localparam logic [9:0]  CSM_IDX_STATUS     = 10'h011;

  // Values after reset.
  localparam logic [6:0]  CSM_RST_CHAN_TWO   = 7'h01;
  localparam logic [6:0]  CSM_RST_CHAN_THREE = 7'h02;
  localparam logic [6:0]  CSM_RST_CHAN_FOUR  = 7'h03;
  localparam logic [1:0]  CSM_RST_FORMAT     = 2'h0;

  // Field positions.
  localparam int unsigned CSM_LINE_SEL_BIT   = 6;
  localparam int unsigned CSM_STAT_UNDERRUN  = 0;
  localparam int unsigned CSM_STAT_LEVEL_LSB = 1;
  localparam int unsigned CSM_STAT_ACTIVE    = 7;

  // Serial framing counts: 32 bit clocks per slot, 32 slots per half frame.
  localparam int unsigned CSM_SAMPLE_W       = 32;
  localparam int unsigned CSM_FIFO_DEPTH     = 32;
  localparam logic [11:0] CSM_POS_FIRST      = 12'h000;
  localparam logic [11:0] CSM_POS_I2S_FIRST  = 12'hFFF;
  localparam logic [11:0] CSM_POS_LAST       = 12'h7FF;

  typedef enum logic [1:0] {
    CSM_FMT_TDM             = 2'b00,
    CSM_FMT_I2S             = 2'b01,
    CSM_FMT_LEFT_JUSTIFIED  = 2'b10
  } csm_fmt_t;

  typedef struct packed {
    logic       line_sel;
    logic [5:0] slot_idx;
  } csm_chan_cfg_t;

  typedef struct packed {
    logic [CSM_SAMPLE_W-1:0] chan_four;
    logic [CSM_SAMPLE_W-1:0] chan_three;
    logic [CSM_SAMPLE_W-1:0] chan_two;
  } csm_frame_t;

  // Format code 2'b11 is not defined and behaves as TDM.
  function automatic logic csm_is_tdm(input logic [1:0] fmt);
    return (fmt != CSM_FMT_I2S) && (fmt != CSM_FMT_LEFT_JUSTIFIED);
  endfunction

  // True when bit position pos of the current half lies in the slot chosen by idx.
  function automatic logic csm_slot_hit(input logic [5:0]  idx,
                                        input logic [11:0] pos,
                                        input logic [1:0]  fmt,
                                        input logic        half);
    logic hit;
    hit = 1'b0;
    if (!pos[11]) begin
      if (csm_is_tdm(fmt)) begin
        hit = (pos[10:5] == idx);
      end else begin
        hit = !pos[10] && (idx[5] == half) && (pos[9:5] == idx[4:0]);
      end
    end
    return hit;
  endfunction

endpackage

// >>> verilog/csm_fifo.sv
// Frame FIFO that holds channel sample words between the user side and the serial side.
`timescale 1ns/1ps
`default_nettype none
module csm_fifo #(
  parameter int unsigned WIDTH = 96,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic                       pclk,      // System clock.
  input  wire logic                       presetn,   // Asynchronous reset, active low.
  input  wire logic                       in_valid,  // Write word offered.
  output logic                            in_ready,  // Space for a word.
  input  wire logic [WIDTH-1:0]           in_data,   // Word to store.
  output logic                            out_valid, // Word available.
  input  wire logic                       out_ready, // Reader takes the word.
  output logic [WIDTH-1:0]                out_data,  // Oldest word.
  output logic [$clog2(DEPTH+1)-1:0]      level      // Words held.
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH+1);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } csm_fifo_state_t;

  csm_fifo_state_t  st_ff;
  csm_fifo_state_t  nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st_ff.count != CNT_W'(DEPTH));
  assign out_valid = (st_ff.count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_ff.rd_ptr];
  assign level     = st_ff.count;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr_ptr = (st_ff.wr_ptr == PTR_W'(DEPTH-1)) ? '0 : PTR_W'(st_ff.wr_ptr + 1'b1);
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == PTR_W'(DEPTH-1)) ? '0 : PTR_W'(st_ff.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      nxt_st.count = CNT_W'(st_ff.count + 1'b1);
    end else if (pop && !push) begin
      nxt_st.count = CNT_W'(st_ff.count - 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage needs no reset; only words counted as held are ever read.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[st_ff.wr_ptr] <= in_data;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/csm_host_model.sv
// Host side of the serial link: makes bit clock and frame sync, records both data lines.
`timescale 1ns/1ps
`default_nettype none
module csm_host_model (
  output var logic  bit_clock_pin,       // Bit clock, still between frames.
  output var logic  frame_sync_pin,      // Frame sync.
  input  wire logic primary_serial_out,  // Primary data line.
  input  wire logic primary_serial_oe_n, // Primary drive enable.
  input  wire logic general_output_pin,  // Secondary data line.
  input  wire logic general_output_oe_n  // Secondary drive enable.
);
  logic [2047:0] p_d;
  logic [2047:0] p_e;
  logic [2047:0] g_d;
  logic [2047:0] g_e;

  initial begin
    bit_clock_pin = 1'b0;
    frame_sync_pin = 1'b0;
  end

  // Position p is launched after fall p, so it is recorded at the following fall.
  task automatic run_frame(input logic [1:0] fmt);
    int n;
    int p;
    for (n = -1; n < 2051; n++) begin
      if (fmt == 2'h0) begin
        frame_sync_pin = (n == 0);
      end else if (fmt == 2'h1) begin
        frame_sync_pin = (n < 0) || (n >= 1024);
      end else begin
        frame_sync_pin = (n >= 0) && (n < 1024);
      end
      #24 bit_clock_pin = 1'b1;
      #24 bit_clock_pin = 1'b0;
      p = n - 1 - int'(fmt == 2'h1);
      if (p >= 0 && p < 2048) begin
        p_d[p] = primary_serial_out;
        p_e[p] = primary_serial_oe_n;
        g_d[p] = general_output_pin;
        g_e[p] = general_output_oe_n;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/csm_slot_mapper_tb.sv
// Self-checking bench for the channel slot mapper.
`timescale 1ns/1ps
`default_nettype none
module csm_slot_mapper_tb;
  import csm_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_valid;
  logic        frame_ready;
  csm_frame_t  frame_data;
  wire         bit_clock_pin;
  wire         frame_sync_pin;
  logic        primary_serial_out;
  logic        primary_serial_oe_n;
  logic        general_output_pin;
  logic        general_output_oe_n;
  int          fails;
  int          checked;

  csm_slot_mapper u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .frame_valid, .frame_ready, .frame_data, .bit_clock_pin, .frame_sync_pin,
    .primary_serial_out, .primary_serial_oe_n, .general_output_pin, .general_output_oe_n);
  csm_host_model u_host (.bit_clock_pin, .frame_sync_pin, .primary_serial_out, .primary_serial_oe_n,
    .general_output_pin, .general_output_oe_n);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] samp(input int k, input int ch);
    return 32'h9A3C5A81 ^ (32'h01010100 * ch) ^ k;
  endfunction

  // One APB transfer; read data and error are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, {idx, 2'b00}, d, r, e);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, {idx, 2'b00}, 32'h0, r, e);
    chk(r, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rd(CSM_IDX_CHAN_TWO, 32'h01);
    rd(CSM_IDX_CHAN_THREE, 32'h02);
    rd(CSM_IDX_CHAN_FOUR, 32'h03);
    wr(CSM_IDX_CHAN_THREE, 32'hFFFFFFFF);
    rd(CSM_IDX_CHAN_THREE, 32'h7F);
    apb(1'b0, 12'h3FC, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // Write then read channel two back to back, with no idle cycle between them.
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= {CSM_IDX_CHAN_TWO, 2'b00};
    pwdata <= 32'h0000002A;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    penable <= 1'b0;
    pwrite <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk(prdata, 32'h2A);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    $display("test regs done");
  endtask

  // Fills the FIFO, then offers one more word that must be refused.
  task automatic t_fill;
    int k;
    for (k = 0; k < 33; k++) begin
      frame_valid <= 1'b1;
      frame_data <= csm_frame_t'({samp(k, 2), samp(k, 1), samp(k, 0)});
      @(posedge pclk);
      chk({31'h0, frame_ready}, {31'h0, k < 32});
    end
    frame_valid <= 1'b0;
    @(posedge pclk);
    rd(CSM_IDX_STATUS, 32'h40);
    $display("test fill done");
  endtask

  task automatic chan_chk(input logic [6:0] cfg, input logic [31:0] s);
    int b;
    int p;
    logic e;
    logic d;
    for (b = 0; b < 33; b++) begin
      p = int'(cfg[5:0]) * 32 + b;
      if (p < 2048) begin
        e = cfg[6] ? u_host.g_e[p] : u_host.p_e[p];
        d = cfg[6] ? u_host.g_d[p] : u_host.p_d[p];
        if (b < 32) begin
          chk({30'h0, e, d}, {30'h0, 1'b0, s[31-b]});
        end else begin
          chk({31'h0, e}, 32'h1);
        end
      end
    end
  endtask

  task automatic t_format(input logic [1:0] fmt, input logic [6:0] c2, input logic [6:0] c3,
                          input logic [6:0] c4, input int k);
    wr(CSM_IDX_CHAN_TWO, {25'h0, c2});
    wr(CSM_IDX_CHAN_THREE, {25'h0, c3});
    wr(CSM_IDX_CHAN_FOUR, {25'h0, c4});
    wr(CSM_IDX_FRAME_CFG, {30'h0, fmt});
    rd(CSM_IDX_FRAME_CFG, {30'h0, fmt});
    u_host.run_frame(fmt);
    chan_chk(c2, samp(k, 0));
    chan_chk(c3, samp(k, 1));
    chan_chk(c4, samp(k, 2));
    $display("test format %0d done", fmt);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    frame_valid = 1'b0;
    frame_data = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_fill;
    t_format(2'h0, 7'h00, 7'h7F, 7'h05, 0);
    t_format(2'h2, 7'h5F, 7'h20, 7'h3F, 1);
    t_format(2'h1, 7'h21, 7'h68, 7'h40, 2);
    rd(CSM_IDX_STATUS, 32'hBA);
    results;
  end

  initial begin
    #400000;
    fails++;
    results;
  end
endmodule
`default_nettype wire
